// *** hw/serial_port.sv ***
// Serial port with modem handshake, APB registers and transmit FIFO
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Transmit line rests at mark between and outside characters.
// - Characters go out only while own request and clear-to-send are both on; the code checks clear-to-send only before each start bit.
// - Half duplex: receiver ignores the line while request is on; a character whose start bit is already checked is still received.
// - Full duplex: request state does not affect transmitter or receiver.
// - Half duplex with request off: transmit and request drivers float.
// - Raise request first, then wait for clear-to-send before transmitting.
// - After dropping request, raise it again only after clear-to-send went off.
// - Rates 110 to 19200 baud for both directions, default 1200.
// - All port settings held in one configuration table.
// - Test mode sends a fixed symmetrical pattern continuously.
// - Output write protect rejects writes to outputs; memory write protect rejects writes to the register table.
// - Flag mode only in full duplex; otherwise disabled and error reported.
module serial_port
    import serial_port_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic receive_data_i,
    input wire logic clear_to_send_i,
    output logic transmit_data_o,
    output logic transmit_data_oe_n_o,
    output logic request_to_send_o,
    output logic request_to_send_oe_n_o,
    output logic flag_mode_active_o
);
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_WAIT_CTS,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP,
        TX_WAIT_CTS_OFF
    } tx_state_type;

    typedef struct packed {
        logic [31:0] cfg;
        tx_state_type st;
        logic rts;
        logic line;
        logic [23:0] cnt;
        logic [3:0] idx;
        logic [7:0] shreg;
        logic par;
        logic stops;
        logic [7:0] rx_data;
        logic rx_full;
        logic rx_overrun;
        logic frame_err;
        logic parity_err;
        logic wr_rejected;
        logic [31:0] prdata;
    } state_type;

    state_type state_q, state_d;

    byte_stream_if #(.WIDTH(8)) tx_in ();
    byte_stream_if #(.WIDTH(8)) tx_out ();
    byte_stream_if #(.WIDTH(8)) rx_s ();

    logic port_en, half, two_stop, test_mode, flag_sel;
    logic [2:0] baud_sel;
    logic [1:0] parity_sel;
    logic [23:0] bit_len;
    logic apb_wr, apb_rd, rx_enable, rx_ferr, rx_perr, tx_busy;

    // ****************************************
    // Configuration decode
    // ****************************************
    assign port_en = state_q.cfg[CFG_ENABLE_BIT];
    assign half = state_q.cfg[CFG_HALF_DUPLEX_BIT];
    assign baud_sel = state_q.cfg[CFG_BAUD_LSB +: 3];
    assign parity_sel = state_q.cfg[CFG_PARITY_LSB +: 2];
    assign two_stop = state_q.cfg[CFG_TWO_STOP_BIT];
    assign test_mode = state_q.cfg[CFG_TEST_BIT];
    assign flag_sel = state_q.cfg[CFG_FLAG_BIT];
    assign bit_len = bit_cycles(baud_sel) - 24'h1;
    // Flag mode needs full duplex and the byte-count protocol
    assign flag_mode_active_o = flag_sel && !half && !state_q.cfg[CFG_PROTOCOL_BIT];

    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign apb_rd = psel_i && !penable_i && !pwrite_i;
    assign pready_o = 1'b1;
    assign prdata_o = state_q.prdata;
    assign pslverr_o = psel_i && penable_i && !(paddr_i inside
        {CFG_OFFSET, STATUS_OFFSET, TXDATA_OFFSET, RXDATA_OFFSET, WRCHECK_OFFSET});

    assign tx_in.valid = apb_wr && paddr_i == TXDATA_OFFSET;
    assign tx_in.data = pwdata_i[7:0];
    assign rx_s.ready = !state_q.rx_full || (apb_rd && paddr_i == RXDATA_OFFSET);

    // ****************************************
    // Line drivers
    // ****************************************
    assign transmit_data_o = state_q.line;
    assign request_to_send_o = state_q.rts;
    // Drivers float when request is off in half duplex
    assign transmit_data_oe_n_o = half && !state_q.rts;
    assign request_to_send_oe_n_o = half && !state_q.rts;
    // Request only gates reception in half duplex
    assign rx_enable = port_en && !test_mode && !(half && state_q.rts);
    assign tx_busy = state_q.st inside {TX_START, TX_DATA, TX_PARITY, TX_STOP};
    assign tx_out.ready = port_en && !test_mode && state_q.st == TX_WAIT_CTS
                          && clear_to_send_i;

    stream_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_s(tx_in),
        .out_s(tx_out)
    );

    serial_receiver u_receiver (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .rx_i(receive_data_i),
        .enable_i(rx_enable),
        .bit_len_i(bit_len),
        .parity_i(parity_sel),
        .two_stop_i(two_stop),
        .out_s(rx_s),
        .frame_err_o(rx_ferr),
        .parity_err_o(rx_perr)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        if (state_q.cnt != '0) begin
            state_d.cnt = state_q.cnt - 24'h1;
        end

        // Register writes
        if (apb_wr) begin
            case (paddr_i)
                CFG_OFFSET: state_d.cfg = pwdata_i & 32'h00FF_1FFF;
                STATUS_OFFSET: begin
                    // Write one to clear the sticky bits
                    if (pwdata_i[3]) state_d.rx_overrun = 1'b0;
                    if (pwdata_i[4]) state_d.frame_err = 1'b0;
                    if (pwdata_i[5]) state_d.parity_err = 1'b0;
                    if (pwdata_i[6]) state_d.wr_rejected = 1'b0;
                end
                WRCHECK_OFFSET: begin
                    // Protocol layer asks before applying a host write
                    if ((pwdata_i[1:0] == WR_CLASS_OUTPUT && state_q.cfg[CFG_OUT_WP_BIT])
                        || (pwdata_i[1:0] == WR_CLASS_MEMORY && state_q.cfg[CFG_MEM_WP_BIT])) begin
                        state_d.wr_rejected = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // Register reads, captured in setup phase
        if (apb_rd) begin
            case (paddr_i)
                CFG_OFFSET: state_d.prdata = state_q.cfg;
                STATUS_OFFSET: state_d.prdata = {24'h0, half && flag_sel, state_q.wr_rejected,
                    state_q.parity_err, state_q.frame_err, state_q.rx_overrun,
                    state_q.rx_full, !tx_in.ready, tx_busy || tx_out.valid};
                RXDATA_OFFSET: begin
                    state_d.prdata = {24'h0, state_q.rx_data};
                    state_d.rx_full = 1'b0;
                end
                default: state_d.prdata = 32'h0;
            endcase
        end

        // Receive holding register; set wins over the read clear
        if (rx_s.valid) begin
            if (rx_s.ready) begin
                state_d.rx_data = rx_s.data;
                state_d.rx_full = 1'b1;
            end else begin
                state_d.rx_overrun = 1'b1;
            end
        end
        if (rx_ferr) state_d.frame_err = 1'b1;
        if (rx_perr) state_d.parity_err = 1'b1;

        // Transmit sequencer
        case (state_q.st)
            TX_IDLE: begin
                state_d.line = 1'b1;
                if (port_en && (tx_out.valid || test_mode)) begin
                    state_d.rts = 1'b1;
                    state_d.st = TX_WAIT_CTS;
                end
            end
            TX_WAIT_CTS: begin
                // Nothing is sent until clear-to-send answers
                if (clear_to_send_i && (tx_out.valid || test_mode)) begin
                    state_d.shreg = test_mode ? TEST_PATTERN : tx_out.data;
                    state_d.st = TX_START;
                    state_d.cnt = bit_len;
                    state_d.line = 1'b0;
                end else if (!tx_out.valid && !test_mode) begin
                    state_d.rts = 1'b0;
                    state_d.st = TX_WAIT_CTS_OFF;
                end
            end
            TX_START: begin
                if (state_q.cnt == '0) begin
                    state_d.st = TX_DATA;
                    state_d.idx = 4'h0;
                    state_d.par = 1'b0;
                    state_d.cnt = bit_len;
                    state_d.line = state_q.shreg[0];
                end
            end
            TX_DATA: begin
                if (state_q.cnt == '0) begin
                    state_d.cnt = bit_len;
                    state_d.par = state_q.par ^ state_q.shreg[0];
                    state_d.shreg = {1'b0, state_q.shreg[7:1]};
                    state_d.idx = state_q.idx + 4'h1;
                    state_d.line = state_q.shreg[1];
                    if (state_q.idx == 4'(DATA_BITS - 1)) begin
                        state_d.stops = two_stop;
                        if (parity_sel == 2'(PARITY_NONE)) begin
                            state_d.st = TX_STOP;
                            state_d.line = 1'b1;
                        end else begin
                            state_d.st = TX_PARITY;
                            state_d.line = (state_q.par ^ state_q.shreg[0])
                                           ^ (parity_sel == 2'(PARITY_ODD));
                        end
                    end
                end
            end
            TX_PARITY: begin
                if (state_q.cnt == '0) begin
                    state_d.cnt = bit_len;
                    state_d.st = TX_STOP;
                    state_d.line = 1'b1;
                end
            end
            TX_STOP: begin
                if (state_q.cnt == '0) begin
                    state_d.cnt = bit_len;
                    if (state_q.stops) begin
                        state_d.stops = 1'b0;
                    end else if (half && !tx_out.valid && !test_mode) begin
                        // Last stop bit is fully out
                        state_d.rts = 1'b0;
                        state_d.st = TX_WAIT_CTS_OFF;
                    end else begin
                        // Request stays up while more data or test mode is pending; in full duplex TX_WAIT_CTS drops it otherwise
                        state_d.st = TX_WAIT_CTS;
                    end
                end
            end
            TX_WAIT_CTS_OFF: begin
                state_d.line = 1'b1;
                // No new request before clear-to-send dropped
                if (!clear_to_send_i) begin
                    state_d.st = TX_IDLE;
                end
            end
            default: state_d.st = TX_IDLE;
        endcase

        // Port disable aborts any character and drops request
        if (!port_en && state_q.st != TX_IDLE && state_q.st != TX_WAIT_CTS_OFF) begin
            state_d.rts = 1'b0;
            state_d.line = 1'b1;
            state_d.st = TX_WAIT_CTS_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= '0;
            state_q.cfg <= CFG_RESET;
            state_q.line <= 1'b1;
            state_q.st <= TX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
endmodule : serial_port
`default_nettype wire

// *** include/serial_port_pkg.sv ***
// Shared constants and types of the serial port
`default_nettype none
package serial_port_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] CFG_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] TXDATA_OFFSET = 12'h008;
    localparam logic [11:0] RXDATA_OFFSET = 12'h00C;
    localparam logic [11:0] WRCHECK_OFFSET = 12'h010;

    // ****************************************
    // Configuration fields
    // ****************************************
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_HALF_DUPLEX_BIT = 1;
    localparam int CFG_BAUD_LSB = 2;
    localparam int CFG_PARITY_LSB = 5;
    localparam int CFG_TWO_STOP_BIT = 7;
    localparam int CFG_PROTOCOL_BIT = 8;
    localparam int CFG_OUT_WP_BIT = 9;
    localparam int CFG_MEM_WP_BIT = 10;
    localparam int CFG_FLAG_BIT = 11;
    localparam int CFG_TEST_BIT = 12;
    localparam int CFG_ADDR_LSB = 16;

    // Disabled, odd, 1 stop, 1200 baud, full duplex, both protects on
    localparam logic [31:0] CFG_RESET = 32'h0000_060C;

    // ****************************************
    // Rates and timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_COUNT = 8;
    localparam int BAUD_TABLE [BAUD_COUNT] = '{110, 300, 600, 1200, 2400, 4800, 9600, 19200};
    localparam int DATA_BITS = 8;
    localparam logic [7:0] TEST_PATTERN = 8'h55;

    // Write check classes
    localparam logic [1:0] WR_CLASS_NONE = 2'h0;
    localparam logic [1:0] WR_CLASS_OUTPUT = 2'h1;
    localparam logic [1:0] WR_CLASS_MEMORY = 2'h2;

    typedef enum logic [1:0] {
        PARITY_ODD,
        PARITY_EVEN,
        PARITY_NONE
    } parity_type;

    function automatic logic [23:0] bit_cycles(input logic [2:0] sel);
        bit_cycles = 24'(CLK_HZ / BAUD_TABLE[sel]);
    endfunction : bit_cycles

endpackage : serial_port_pkg
`default_nettype wire

// *** include/byte_stream_if.sv ***
// Valid/ready byte stream between the port's modules
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// *** hw/stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    byte_stream_if.sink in_s,
    byte_stream_if.source out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } state_type;

    state_type state_q, state_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_s.ready = (state_q.count != (AW+1)'(DEPTH));
    assign out_s.valid = (state_q.count != '0);
    assign out_s.data = mem[state_q.rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        state_d = state_q;
        if (push) begin
            state_d.wr_ptr = AW'((32'(state_q.wr_ptr) + 1) % DEPTH);
        end
        if (pop) begin
            state_d.rd_ptr = AW'((32'(state_q.rd_ptr) + 1) % DEPTH);
        end
        state_d.count = state_q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
        if (push) begin
            mem[state_q.wr_ptr] <= in_s.data;
        end
    end
endmodule : stream_fifo
`default_nettype wire

// *** hw/serial_receiver.sv ***
// Character receiver with mid-bit sampling
`timescale 1ns/100ps
`default_nettype none
module serial_receiver
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic rx_i,
    input wire logic enable_i,
    input wire logic [23:0] bit_len_i,
    input wire logic [1:0] parity_i,
    input wire logic two_stop_i,
    byte_stream_if.source out_s,
    output logic frame_err_o,
    output logic parity_err_o
);
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } rx_state_type;

    typedef struct packed {
        rx_state_type st;
        logic [23:0] cnt;
        logic [3:0] idx;
        logic [7:0] shreg;
        logic par;
        logic stops;
        logic [7:0] data;
        logic valid;
        logic ferr;
        logic perr;
    } state_type;

    state_type state_q, state_d;

    assign out_s.valid = state_q.valid;
    assign out_s.data = state_q.data;
    assign frame_err_o = state_q.ferr;
    assign parity_err_o = state_q.perr;

    always_comb begin
        state_d = state_q;
        state_d.ferr = 1'b0;
        state_d.perr = 1'b0;
        if (out_s.ready) begin
            state_d.valid = 1'b0;
        end
        if (state_q.cnt != '0) begin
            state_d.cnt = state_q.cnt - 24'h1;
        end
        case (state_q.st)
            RX_IDLE: begin
                // Receiver gated off while transmitting in half duplex
                if (enable_i && !rx_i) begin
                    state_d.st = RX_START;
                    state_d.cnt = bit_len_i >> 1;
                end
            end
            RX_START: begin
                if (state_q.cnt == '0) begin
                    state_d.st = rx_i ? RX_IDLE : RX_DATA;
                    state_d.cnt = bit_len_i;
                    state_d.idx = 4'h0;
                    state_d.par = 1'b0;
                end
            end
            RX_DATA: begin
                if (state_q.cnt == '0) begin
                    // Least significant bit arrives first
                    state_d.shreg = {rx_i, state_q.shreg[7:1]};
                    state_d.par = state_q.par ^ rx_i;
                    state_d.cnt = bit_len_i;
                    state_d.idx = state_q.idx + 4'h1;
                    if (state_q.idx == 4'(DATA_BITS - 1)) begin
                        state_d.st = (parity_i == 2'(PARITY_NONE)) ? RX_STOP : RX_PARITY;
                        state_d.stops = two_stop_i;
                    end
                end
            end
            RX_PARITY: begin
                if (state_q.cnt == '0) begin
                    state_d.perr = (state_q.par ^ rx_i) != (parity_i == 2'(PARITY_ODD));
                    state_d.cnt = bit_len_i;
                    state_d.st = RX_STOP;
                    state_d.stops = two_stop_i;
                end
            end
            RX_STOP: begin
                if (state_q.cnt == '0) begin
                    state_d.cnt = bit_len_i;
                    if (!rx_i) begin
                        state_d.ferr = 1'b1;
                        state_d.st = RX_IDLE;
                    end else if (state_q.stops) begin
                        state_d.stops = 1'b0;
                    end else begin
                        state_d.st = RX_IDLE;
                        state_d.data = state_q.shreg;
                        state_d.valid = 1'b1;
                    end
                end
            end
            default: state_d.st = RX_IDLE;
        endcase
        if (!enable_i && state_q.st == RX_START) begin
            state_d.st = RX_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule : serial_receiver
`default_nettype wire

// *** testbench/serial_port_monitor.sv ***
// Pin-level checks of the serial port
`timescale 1ns/100ps
`default_nettype none
module serial_port_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic receive_data_i,
    input wire logic clear_to_send_i,
    input wire logic transmit_data_o,
    input wire logic transmit_data_oe_n_o,
    input wire logic request_to_send_o,
    input wire logic request_to_send_oe_n_o,
    input wire logic flag_mode_active_o
);
    logic cts_low_seen_q;
    // Cleared once a request is answered, so a rearm needs a fresh low
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !clear_to_send_i) begin
            cts_low_seen_q <= 1'b1;
        end else if (request_to_send_o) begin
            cts_low_seen_q <= 1'b0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence rts_raised;
        $rose(request_to_send_o);
    endsequence
    sequence cts_held_off;
        (!clear_to_send_i) [*2];
    endsequence
    chk_idle_mark: assert property (!request_to_send_o |-> transmit_data_o)
        else $error("line off mark without request");
    chk_send_gated: assert property ($fell(transmit_data_o) |->
        request_to_send_o && $past(clear_to_send_i)) else $error("start bit without handshake");
    chk_wait_cts: assert property (rts_raised ##0 cts_held_off |-> transmit_data_o)
        else $error("sent before clear to send");
    chk_rts_rearm: assert property ($rose(request_to_send_o) |->
        $past(cts_low_seen_q)) else $error("request raised before clear to send fell");
    chk_drive_on: assert property (request_to_send_o |->
        !transmit_data_oe_n_o && !request_to_send_oe_n_o) else $error("drivers off during request");
    chk_rts_after_stop: assert property ($fell(request_to_send_o) |->
        $past(transmit_data_o) && $past(transmit_data_o, 2)) else $error("request dropped in char");
    chk_zero_wait: assert property (psel_i && penable_i |-> pready_o)
        else $error("access not answered");
    chk_unmapped_err: assert property (psel_i && penable_i && paddr_i > 12'h010 |->
        pslverr_o && (pwrite_i || prdata_o == 32'h0)) else $error("unmapped access not refused");
endmodule : serial_port_monitor
bind serial_port serial_port_monitor mon_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .receive_data_i(receive_data_i), .clear_to_send_i(clear_to_send_i),
    .transmit_data_o(transmit_data_o), .transmit_data_oe_n_o(transmit_data_oe_n_o),
    .request_to_send_o(request_to_send_o), .request_to_send_oe_n_o(request_to_send_oe_n_o),
    .flag_mode_active_o(flag_mode_active_o));
`default_nettype wire

// *** testbench/modem_model.sv ***
// Behavioural modem: request/clear handshake and character capture
`timescale 1ns/100ps
`default_nettype none
module modem_model #(
    parameter int BIT = 5208,
    parameter int DLY = 20
) (
    input wire logic clk_i,
    input wire logic rts_i,
    input wire logic line_i,
    output logic cts_o,
    output logic [7:0] byte_o,
    output logic got_o
);
    initial begin
        cts_o = 1'b0;
        got_o = 1'b0;
        byte_o = 8'h00;
    end
    // Slow answer on purpose, so the port has to wait
    always begin
        @(posedge clk_i);
        if (rts_i && !cts_o) begin
            repeat (DLY) @(posedge clk_i);
            cts_o <= 1'b1;
        end else if (!rts_i && cts_o) begin
            repeat (DLY) @(posedge clk_i);
            cts_o <= 1'b0;
        end
    end
    always begin
        @(negedge line_i);
        if (cts_o) begin
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                byte_o[i] = line_i;
            end
            got_o = 1'b1;
        end
    end
endmodule : modem_model
`default_nettype wire

// *** testbench/serial_port_tb.sv ***
// Directed bench for the serial port
`timescale 1ns/100ps
`default_nettype none
module serial_port_tb;
    import serial_port_pkg::*;
    localparam int BIT = 100_000_000 / 19200;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic err, pready, pslverr, txd, txd_oe_n, rts, rts_oe_n, cts, got, flag_act;
    logic rxd = 1'b1;
    // Stop, data, start; sent from bit 0 up
    localparam logic [9:0] RX_FRAME = {1'b1, 8'h5A, 1'b0};
    logic [7:0] rx_byte;
    int errors = 0, n_tests = 0;
    initial forever #5 clk_i = ~clk_i;
    serial_port dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .receive_data_i(rxd),
        .clear_to_send_i(cts), .transmit_data_o(txd), .transmit_data_oe_n_o(txd_oe_n),
        .request_to_send_o(rts), .request_to_send_oe_n_o(rts_oe_n),
        .flag_mode_active_o(flag_act));
    // Floating driver reads as mark, as a pull-up would give
    modem_model #(.BIT(BIT)) modem_u (.clk_i(clk_i), .rts_i(rts),
        .line_i(txd_oe_n ? 1'b1 : txd), .cts_o(cts), .byte_o(rx_byte), .got_o(got));
    task stop_test;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task check(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v) begin
            @(posedge clk_i);
            n++;
            if (n > lim) begin
                check("wait timeout", v, s);
                stop_test();
            end
        end
    endtask : wait_sig
    // Setup cycle, access until pready, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        wait_sig(pready, 1'b1, 50);
        rd = prdata;
        err = pslverr;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        apb(0, CFG_OFFSET, 0);
        check("cfg reset", 32'h0000060C, rd);
        apb(0, 12'h020, 0);
        check("unmapped err", 1, err);
        check("unmapped data", 0, rd);
        for (int c = 1; c < 3; c++) begin
            apb(1, WRCHECK_OFFSET, c);
            apb(0, STATUS_OFFSET, 0);
            check("write rejected", 1, rd[6]);
            apb(1, STATUS_OFFSET, 32'h40);
            apb(0, STATUS_OFFSET, 0);
            check("reject cleared", 0, rd[6]);
        end
        // Port still disabled, so the buffer only fills
        for (int i = 0; i < 32; i++) apb(1, TXDATA_OFFSET, i);
        apb(0, STATUS_OFFSET, 0);
        check("fifo full", 1, rd[1]);
        check("rts while disabled", 0, rts);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        apb(1, CFG_OFFSET, 32'h802);
        apb(0, STATUS_OFFSET, 0);
        check("flag illegal", 1, rd[7]);
        check("flag half", 0, flag_act);
        check("oe float", 2'h3, {txd_oe_n, rts_oe_n});
        apb(1, CFG_OFFSET, 32'h800);
        check("flag full", 1, flag_act);
        check("oe drive", 2'h0, {txd_oe_n, rts_oe_n});
        apb(1, CFG_OFFSET, 32'h5D);
        apb(0, CFG_OFFSET, 0);
        check("cfg", 32'h5D, rd);
        apb(1, TXDATA_OFFSET, 32'hA5);
        // Receive a character while request is on
        fork
            for (int i = 0; i < 10; i++) begin
                rxd <= RX_FRAME[i];
                repeat (BIT) @(posedge clk_i);
            end
        join_none
        wait_sig(got, 1'b1, 12 * BIT);
        check("char", 8'hA5, rx_byte);
        wait_sig(rts, 1'b0, 4 * BIT);
        wait_sig(cts, 1'b0, 100);
        check("line mark", 1, txd);
        apb(0, RXDATA_OFFSET, 0);
        check("rx char", 32'h5A, rd);
        apb(1, CFG_OFFSET, 32'h105D);
        wait_sig(txd, 1'b0, 100);
        repeat (BIT + BIT / 2) @(posedge clk_i);
        check("test bit0", 1, txd);
        repeat (BIT) @(posedge clk_i);
        check("test bit1", 0, txd);
        stop_test();
    end
endmodule : serial_port_tb
`default_nettype wire
